// ==== dv/cmfs_field_model.sv ====
`timescale 1ns/1ps
// ****************************************
// controller and field outputs model
// ****************************************
module cmfs_field_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // control from bench
    input  wire logic        wdg_run,
    input  wire logic [17:0] dark,
    input  wire logic [35:0] colour,
    // field side
    output logic [17:0]      ch_green,
    output logic [17:0]      ch_yellow,
    output logic [17:0]      ch_red,
    output logic             watchdog_in
);
    // one lamp per channel for colour codes 0 to 2, none for code 3 or when forced dark, watchdog toggles while running
    always_ff @(posedge clk) begin
        for (int i = 0; i < 18; i++) begin
            ch_green[i]  <= !dark[i] && colour[2*i+:2] == 2'h0;
            ch_yellow[i] <= !dark[i] && colour[2*i+:2] == 2'h1;
            ch_red[i]    <= !dark[i] && colour[2*i+:2] == 2'h2;
        end
        if (rst) watchdog_in <= 1'b0;
        else if (wdg_run) watchdog_in <= ~watchdog_in;
    end
endmodule : cmfs_field_model

// ==== dv/cmfs_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb;
    localparam int MS = 4;
    logic        clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wdg_run;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, ctrl, q;
    logic [3:0]  wb_sel_i;
    logic [17:0] ch_green, ch_yellow, ch_red, dark, led_ch_red, led_ch_yellow, led_ch_green;
    logic [35:0] colour;
    logic        red_enable, special_func1, special_func2, relay_common_input, watchdog_in, conflict_in;
    logic        card_present, ac_low, dc_supply_ok, diag_fail, panel_reset, remote_reset;
    logic        led_ac_power, led_dc_supply_fail, led_watchdog_timer_err, led_conflict, led_red_fail;
    logic        led_dual, led_clearance, led_programming_card_ajar, led_diag_fail, fault_active;
    logic [8:0]  mon;
    int          n_errors, num_checks, cycles, exp_flags, idx;
    int          fl_q[$] = '{cmfs_pkg::FL_PCA, cmfs_pkg::FL_DC, cmfs_pkg::FL_DIAG, cmfs_pkg::FL_CONF};

    // ****************************************
    // design, partner and clock
    // ****************************************
    cmfs_supervisor #(.CYC_PER_MS_P(MS)) cmfs_supervisor_inst (.clk, .rst, .wb_adr_i, .wb_dat_i,
        .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ch_green, .ch_yellow, .ch_red,
        .red_enable, .special_func1, .special_func2, .relay_common_input, .watchdog_in, .conflict_in,
        .card_present, .ac_low, .dc_supply_ok, .diag_fail, .panel_reset, .remote_reset, .led_ac_power,
        .led_dc_supply_fail, .led_watchdog_timer_err, .led_conflict, .led_red_fail, .led_dual,
        .led_clearance, .led_programming_card_ajar, .led_diag_fail, .led_ch_red, .led_ch_yellow,
        .led_ch_green, .fault_active);
    cmfs_field_model cmfs_field_model_inst (.clk, .rst, .wdg_run, .dark, .colour, .ch_green,
        .ch_yellow, .ch_red, .watchdog_in);
    // indicators in flag order, brown-out on top
    assign mon = {~led_ac_power, led_diag_fail, led_programming_card_ajar, led_clearance, led_dual,
                  led_red_fail, led_conflict, led_watchdog_timer_err, led_dc_supply_fail};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            n_errors++;
            conclude();
        end
    end

    // ****************************************
    // tasks and model
    // ****************************************
    function automatic logic [31:0] model_stat();
        return {22'h0, exp_flags != 0, 1'b1, exp_flags[7:0]};
    endfunction : model_stat
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk);
        while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic check_all();
        wb(1'b0, cmfs_pkg::STAT_OFS, 32'h0, q);
        `CHK(q, model_stat())
        `CHK(mon[7:0], exp_flags[7:0])
        `CHK(fault_active, exp_flags != 0)
    endtask : check_all
    task automatic do_reset(input int how);
        if (how == 2) wb(1'b1, cmfs_pkg::CTRL_OFS, ctrl | 32'h100, q);
        else begin
            panel_reset  <= (how == 0);
            remote_reset <= (how == 1);
            step(1);
            panel_reset  <= 1'b0;
            remote_reset <= 1'b0;
        end
        step(2);
    endtask : do_reset
    task automatic timed(input int fl, input int lim);
        int n = 0;
        step((lim - 1) * MS - 2);
        `CHK(mon[fl], 1'b0)
        while (mon[fl] !== 1'b1 && n < 3 * MS + 4) begin
            step(1);
            n++;
        end
        `CHK(mon[fl], 1'b1)
    endtask : timed
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'ha53f));
        {rst, wdg_run, red_enable, card_present, dc_supply_ok, wb_sel_i} = {5'h1f, 4'hf};
        {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, special_func1, special_func2} = '0;
        {relay_common_input, conflict_in, ac_low, diag_fail, panel_reset, remote_reset} = '0;
        {dark, ctrl, n_errors, num_checks, cycles, exp_flags} = '0;
        for (int i = 0; i < 18; i++) colour[2*i+:2] = 2'($urandom % 3);
        idx = $urandom % 18;
        colour[2*idx+:2] = 2'h2;
        step(16);
        rst <= 1'b0;
        step(2);
        // reset values, byte enables, unmapped and read-only places
        wb(1'b0, cmfs_pkg::CTRL_OFS, 32'h0, q);
        `CHK(q, 32'h0)
        wb(1'b0, cmfs_pkg::RFEN_OFS, 32'h0, q);
        `CHK(q, 32'h3ffff)
        wb(1'b0, 8'h40, 32'h0, q);
        `CHK(q, 32'h0)
        wb_sel_i <= 4'h1;
        wb(1'b1, cmfs_pkg::CTRL_OFS, 32'h11f, q);
        wb_sel_i <= 4'hf;
        wb(1'b0, cmfs_pkg::CTRL_OFS, 32'h0, q);
        `CHK(q, 32'h1f)
        wb(1'b1, cmfs_pkg::CTRL_OFS, 32'h0, q);
        wb(1'b1, cmfs_pkg::STAT_OFS, 32'hff, q);
        check_all();
        `CHK({led_ch_red, led_ch_yellow, led_ch_green}, {ch_red, ch_yellow, ch_green})
        $display("test registers done");
        // instant causes: set, held through reset, then cleared
        foreach (fl_q[i]) begin
            {card_present, dc_supply_ok, diag_fail, conflict_in} <= {i != 0, i != 1, i == 2, i == 3};
            step(2);
            exp_flags = 1 << fl_q[i];
            check_all();
            if (i == 3) begin
                wb(1'b0, cmfs_pkg::REC_OFS, 32'h0, q);
                `CHK(q[17:0], ch_green | ch_yellow)
            end
            do_reset(i % 3);
            check_all();
            {card_present, dc_supply_ok, diag_fail, conflict_in} <= 4'hc;
            step(1);
            do_reset(i % 3);
            exp_flags = 0;
            check_all();
        end
        $display("test instant faults done");
        // each blocking condition keeps red fail quiet
        for (int k = 0; k < 5; k++) begin
            {red_enable, special_func1, special_func2, relay_common_input} <= {k != 0, k == 1, k == 2, k == 3};
            if (k == 4) wb(1'b1, cmfs_pkg::RFEN_OFS, ~(32'h1 << idx), q);
            dark[idx] <= 1'b1;
            step(853 * MS);
            `CHK(led_red_fail, 1'b0)
            {red_enable, special_func1, special_func2, relay_common_input} <= 4'h8;
            dark <= '0;
            step(2);
        end
        wb(1'b1, cmfs_pkg::RFEN_OFS, 32'h3ffff, q);
        $display("test red fail gating done");
        // red fail time for both selects, inverted common polarity
        for (int s = 0; s < 2; s++) begin
            ctrl = 32'h10 | s;
            relay_common_input <= 1'b1;
            wb(1'b1, cmfs_pkg::CTRL_OFS, ctrl, q);
            dark[idx] <= 1'b1;
            timed(cmfs_pkg::FL_RF, s ? 1350 : 850);
            exp_flags = 1 << cmfs_pkg::FL_RF;
            wb(1'b0, cmfs_pkg::REC_OFS, 32'h0, q);
            `CHK(q, 32'h1 << idx)
            dark <= '0;
            step(3);
            `CHK(led_ch_red[idx], 1'b0)
            do_reset(s);
            exp_flags = 0;
            check_all();
            `CHK(led_ch_red[idx], 1'b1)
        end
        relay_common_input <= 1'b0;
        $display("test red fail timing done");
        // watchdog time, brown-out time, latch off then on
        for (int s = 0; s < 2; s++) begin
            ctrl = s ? 32'hc : 32'h2;
            wb(1'b1, cmfs_pkg::CTRL_OFS, ctrl, q);
            wdg_run <= 1'b0;
            timed(cmfs_pkg::FL_WDT, s ? 1500 : 1000);
            wdg_run <= 1'b1;
            ac_low <= 1'b1;
            timed(8, s ? 400 : 80);
            ac_low <= 1'b0;
            step(2 * MS);
            exp_flags = s << cmfs_pkg::FL_WDT;
            check_all();
            do_reset(2);
            exp_flags = 0;
            check_all();
        end
        $display("test watchdog done");
        // a green dropping with no yellow is a clearance fault
        idx = (idx + 1) % 18;
        colour[2*idx+:2] <= 2'h0;
        step(3);
        dark[idx] <= 1'b1;
        step(3);
        exp_flags = 1 << cmfs_pkg::FL_CLR;
        check_all();
        wb(1'b0, cmfs_pkg::REC_OFS, 32'h0, q);
        `CHK(q, 32'h1 << idx)
        dark[idx] <= 1'b0;
        do_reset(1);
        exp_flags = 0;
        check_all();
        $display("test clearance done");
        conclude();
    end
endmodule : tb

// ==== logic/cmfs_pkg.sv ====
package cmfs_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int NCH           = 18;
    localparam int TW            = 11;
    localparam logic [TW-1:0] RED_FAIL_ON_MS  = 11'd1350;
    localparam logic [TW-1:0] RED_FAIL_OFF_MS = 11'd850;
    localparam logic [TW-1:0] WDT_ON_MS       = 11'd1000;
    localparam logic [TW-1:0] WDT_OFF_MS      = 11'd1500;
    localparam logic [TW-1:0] BROWN_ON_MS     = 11'd400;
    localparam logic [TW-1:0] BROWN_OFF_MS    = 11'd80;
    localparam logic [TW-1:0] DUAL_MS         = 11'd350;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] RFEN_OFS  = 8'h04;
    localparam logic [7:0] STAT_OFS  = 8'h08;
    localparam logic [7:0] REC_OFS   = 8'h0c;
    localparam logic [7:0] SNAPG_OFS = 8'h10;
    localparam logic [7:0] SNAPY_OFS = 8'h14;
    localparam logic [7:0] SNAPR_OFS = 8'h18;
    localparam int CTRL_RF_SEL  = 0;
    localparam int CTRL_WDT_SEL = 1;
    localparam int CTRL_BO_SEL  = 2;
    localparam int CTRL_WDL_SEL = 3;
    localparam int CTRL_POL_SEL = 4;
    localparam int CTRL_RST_CMD = 8;
    localparam logic [4:0]  CTRL_RESET = 5'h00;
    localparam logic [17:0] RFEN_RESET = 18'h3ffff;

    // ****************************************
    // fault flag positions
    // ****************************************
    localparam int FL_DC   = 0;
    localparam int FL_WDT  = 1;
    localparam int FL_CONF = 2;
    localparam int FL_RF   = 3;
    localparam int FL_DUAL = 4;
    localparam int FL_CLR  = 5;
    localparam int FL_PCA  = 6;
    localparam int FL_DIAG = 7;
    localparam int NFL     = 8;
    localparam int ST_AC    = 8;
    localparam int ST_FAULT = 9;

    typedef enum logic {
        CMFS_MON   = 1'b0,
        CMFS_FAULT = 1'b1
    } cmfs_state_e;
endpackage : cmfs_pkg

// ==== logic/cmfs_qual_timer.sv ====
`timescale 1ns/1ps
module cmfs_qual_timer #(
    parameter int W = 11
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // timing
    input  wire logic         ms_tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    // result
    output logic              expired
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_expired;

    // refuse widths the counter cannot serve
    if (W < 2 || W > 16) begin : g_bad_w
        $error("cmfs_qual_timer: width out of range");
    end

    // count whole ms while the condition holds
    always_comb begin
        next_cnt     = cnt;
        next_expired = expired;
        if (!cond) begin
            next_cnt     = '0;
            next_expired = 1'b0;
        end else if (ms_tick && !expired) begin
            if (cnt + 1'b1 >= limit) begin
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt     <= '0;
            expired <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            expired <= next_expired;
        end
    end

    restart_clr_a: assert property (@(posedge clk) disable iff (rst)
        !cond |=> (cnt == '0) && !expired)
        else $error("timer did not restart");
endmodule : cmfs_qual_timer

// ==== logic/cmfs_supervisor.sv ====
`timescale 1ns/1ps
module cmfs_supervisor #(
    parameter int CYC_PER_MS_P = cmfs_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    // field signals
    input  wire logic [17:0] ch_green,
    input  wire logic [17:0] ch_yellow,
    input  wire logic [17:0] ch_red,
    input  wire logic        red_enable,
    input  wire logic        special_func1,
    input  wire logic        special_func2,
    input  wire logic        relay_common_input,
    input  wire logic        watchdog_in,
    input  wire logic        conflict_in,
    // supply and unit status
    input  wire logic        card_present,
    input  wire logic        ac_low,
    input  wire logic        dc_supply_ok,
    input  wire logic        diag_fail,
    // reset inputs
    input  wire logic        panel_reset,
    input  wire logic        remote_reset,
    // indicators
    output logic             led_ac_power,
    output logic             led_dc_supply_fail,
    output logic             led_watchdog_timer_err,
    output logic             led_conflict,
    output logic             led_red_fail,
    output logic             led_dual,
    output logic             led_clearance,
    output logic             led_programming_card_ajar,
    output logic             led_diag_fail,
    output logic [17:0]      led_ch_red,
    output logic [17:0]      led_ch_yellow,
    output logic [17:0]      led_ch_green,
    output logic             fault_active
);
    localparam int NCH = cmfs_pkg::NCH;
    localparam int TW  = cmfs_pkg::TW;
    localparam int TBW = $clog2(CYC_PER_MS_P + 1);

    // state names in local scope
    localparam cmfs_pkg::cmfs_state_e CMFS_MON   = cmfs_pkg::CMFS_MON;
    localparam cmfs_pkg::cmfs_state_e CMFS_FAULT = cmfs_pkg::CMFS_FAULT;

    // refuse a timebase the divider cannot serve
    if (CYC_PER_MS_P < 2) begin : g_bad_cyc
        $error("cmfs_supervisor: timebase too short");
    end

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] cmfs_merge(input logic [31:0] old, input logic [31:0] din,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = din[8*b +: 8];
        end
        return r;
    endfunction : cmfs_merge

    // ****************************************
    // millisecond timebase
    // ****************************************
    logic [TBW-1:0] ms_cnt;
    logic [TBW-1:0] next_ms_cnt;
    logic           ms_tick;

    // free running divider
    always_comb begin
        ms_tick     = (ms_cnt == TBW'(CYC_PER_MS_P - 1));
        next_ms_cnt = ms_tick ? '0 : ms_cnt + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) ms_cnt <= '0;
        else     ms_cnt <= next_ms_cnt;
    end

    // ****************************************
    // input conditioning
    // ****************************************
    logic [4:0]     ctrl;
    logic           rc_active;
    logic           mon_en;
    logic           rf_en;
    logic [NCH-1:0] none_on;
    logic [NCH-1:0] dual_on;
    logic [NCH-1:0] prev_green;
    logic           prev_wd;
    logic           prev_brown;
    logic           wd_edge;

    // monitor gating
    always_comb begin
        rc_active = relay_common_input ^ ctrl[cmfs_pkg::CTRL_POL_SEL];
        mon_en    = red_enable & ~rc_active;
        rf_en     = mon_en & ~special_func1 & ~special_func2;
        none_on   = ~(ch_green | ch_yellow | ch_red);
        dual_on   = (ch_green & ch_yellow) | (ch_green & ch_red) | (ch_yellow & ch_red);
        wd_edge   = watchdog_in ^ prev_wd;
    end

    // ****************************************
    // qualification timers
    // ****************************************
    logic [NCH-1:0] rfen;
    logic [NCH-1:0] rf_exp;
    logic [NCH-1:0] dual_exp;
    logic [TW-1:0]  rf_limit;
    logic [TW-1:0]  wd_limit;
    logic [TW-1:0]  bo_limit;
    logic           wd_exp;
    logic           brown;
    logic           power_evt;

    // switch selected limits
    always_comb begin
        rf_limit = ctrl[cmfs_pkg::CTRL_RF_SEL] ? cmfs_pkg::RED_FAIL_ON_MS : cmfs_pkg::RED_FAIL_OFF_MS;
        wd_limit = ctrl[cmfs_pkg::CTRL_WDT_SEL] ? cmfs_pkg::WDT_ON_MS : cmfs_pkg::WDT_OFF_MS;
        bo_limit = ctrl[cmfs_pkg::CTRL_BO_SEL] ? cmfs_pkg::BROWN_ON_MS : cmfs_pkg::BROWN_OFF_MS;
    end

    // per-channel red fail and dual indication timers
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        cmfs_qual_timer #(.W(TW)) u_rf (
            .clk     (clk),
            .rst     (rst),
            .ms_tick (ms_tick),
            .cond    (rf_en & rfen[i] & none_on[i]),
            .limit   (rf_limit),
            .expired (rf_exp[i])
        );
        cmfs_qual_timer #(.W(TW)) u_dual (
            .clk     (clk),
            .rst     (rst),
            .ms_tick (ms_tick),
            .cond    (mon_en & dual_on[i]),
            .limit   (cmfs_pkg::DUAL_MS),
            .expired (dual_exp[i])
        );
    end

    // watchdog must toggle within its window
    cmfs_qual_timer #(.W(TW)) u_wd (
        .clk     (clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .cond    (~wd_edge),
        .limit   (wd_limit),
        .expired (wd_exp)
    );

    // low line must persist to count as brown-out
    cmfs_qual_timer #(.W(TW)) u_bo (
        .clk     (clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .cond    (ac_low),
        .limit   (bo_limit),
        .expired (brown)
    );

    // ****************************************
    // fault latch and channel record
    // ****************************************
    logic                  cmd_pulse;
    logic                  reset_req;
    logic [NCH-1:0]        clr_evt;
    logic [NCH-1:0]        chan_fail;
    logic [cmfs_pkg::NFL-1:0] flags;
    logic [cmfs_pkg::NFL-1:0] set_fl;
    logic [cmfs_pkg::NFL-1:0] next_flags;
    cmfs_pkg::cmfs_state_e state;
    cmfs_pkg::cmfs_state_e next_state;
    logic [NCH-1:0]        rec;
    logic [NCH-1:0]        next_rec;
    logic [NCH-1:0]        snap_g;
    logic [NCH-1:0]        snap_y;
    logic [NCH-1:0]        snap_r;
    logic [NCH-1:0]        next_snap_g;
    logic [NCH-1:0]        next_snap_y;
    logic [NCH-1:0]        next_snap_r;

    // event collection, set wins over any clear
    always_comb begin
        reset_req = panel_reset | remote_reset | cmd_pulse;
        power_evt = brown & ~prev_brown;
        clr_evt   = prev_green & ~ch_green & ~ch_yellow & {NCH{mon_en}};
        chan_fail = rf_exp | dual_exp | clr_evt;
        set_fl                     = '0;
        set_fl[cmfs_pkg::FL_DC]    = ~dc_supply_ok;
        set_fl[cmfs_pkg::FL_WDT]   = wd_exp;
        set_fl[cmfs_pkg::FL_CONF]  = conflict_in;
        set_fl[cmfs_pkg::FL_RF]    = |rf_exp;
        set_fl[cmfs_pkg::FL_DUAL]  = |dual_exp;
        set_fl[cmfs_pkg::FL_CLR]   = |clr_evt;
        set_fl[cmfs_pkg::FL_PCA]   = ~card_present;
        set_fl[cmfs_pkg::FL_DIAG]  = diag_fail;
        next_flags = reset_req ? '0 : flags;
        if (power_evt && !ctrl[cmfs_pkg::CTRL_WDL_SEL]) begin
            next_flags[cmfs_pkg::FL_WDT] = 1'b0;
        end
        next_flags = next_flags | set_fl;
        next_state = CMFS_MON;
        if (|next_flags) next_state = CMFS_FAULT;
        next_rec    = rec;
        next_snap_g = snap_g;
        next_snap_y = snap_y;
        next_snap_r = snap_r;
        unique case (state)
            CMFS_MON: begin
                if (next_state == CMFS_FAULT) begin
                    next_rec    = conflict_in ? (ch_green | ch_yellow) : chan_fail;
                    next_snap_g = ch_green;
                    next_snap_y = ch_yellow;
                    next_snap_r = ch_red;
                end
            end
            CMFS_FAULT: begin
                if (next_state == CMFS_MON) next_rec = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags      <= '0;
            state      <= CMFS_MON;
            rec        <= '0;
            snap_g     <= '0;
            snap_y     <= '0;
            snap_r     <= '0;
            prev_green <= '0;
            prev_wd    <= 1'b0;
            prev_brown <= 1'b0;
        end else begin
            flags      <= next_flags;
            state      <= next_state;
            rec        <= next_rec;
            snap_g     <= next_snap_g;
            snap_y     <= next_snap_y;
            snap_r     <= next_snap_r;
            prev_green <= ch_green;
            prev_wd    <= watchdog_in;
            prev_brown <= brown;
        end
    end

    // ****************************************
    // indicator outputs
    // ****************************************
    // live channel status while monitoring, frozen view while faulted
    always_ff @(posedge clk) begin
        if (rst) begin
            led_ch_green <= '0;
            led_ch_yellow <= '0;
            led_ch_red   <= '0;
            fault_active <= 1'b0;
            led_ac_power <= 1'b0;
            {led_diag_fail, led_programming_card_ajar, led_clearance, led_dual,
             led_red_fail, led_conflict, led_watchdog_timer_err, led_dc_supply_fail} <= '0;
        end else begin
            led_ch_green  <= (next_state == CMFS_FAULT) ? next_snap_g : ch_green;
            led_ch_yellow <= (next_state == CMFS_FAULT) ? next_snap_y : ch_yellow;
            led_ch_red    <= (next_state == CMFS_FAULT) ? next_snap_r : ch_red;
            fault_active  <= (next_state == CMFS_FAULT);
            led_ac_power  <= ~brown;
            {led_diag_fail, led_programming_card_ajar, led_clearance, led_dual,
             led_red_fail, led_conflict, led_watchdog_timer_err, led_dc_supply_fail} <= next_flags;
        end
    end

    // ****************************************
    // wishbone registers
    // ****************************************
    logic [4:0]  next_ctrl;
    logic [17:0] next_rfen;
    logic        next_cmd_pulse;
    logic        next_ack;
    logic [31:0] next_dat;
    logic [31:0] wr_word;
    logic        wr_go;

    // decode, write on the acknowledged edge, read data ready with ack
    always_comb begin
        next_ack       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wr_go          = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
        next_ctrl      = ctrl;
        next_rfen      = rfen;
        next_cmd_pulse = 1'b0;
        next_dat       = wb_dat_o;
        wr_word        = '0;
        if (wr_go && wb_adr_i == cmfs_pkg::CTRL_OFS) begin
            wr_word        = cmfs_merge({27'h0, ctrl}, wb_dat_i, wb_sel_i);
            next_ctrl      = wr_word[4:0];
            next_cmd_pulse = wr_word[cmfs_pkg::CTRL_RST_CMD];
        end else if (wr_go && wb_adr_i == cmfs_pkg::RFEN_OFS) begin
            wr_word   = cmfs_merge({14'h0, rfen}, wb_dat_i, wb_sel_i);
            next_rfen = wr_word[17:0];
        end
        if (next_ack) begin
            unique case (wb_adr_i)
                cmfs_pkg::CTRL_OFS:  next_dat = {27'h0, ctrl};
                cmfs_pkg::RFEN_OFS:  next_dat = {14'h0, rfen};
                cmfs_pkg::STAT_OFS:  next_dat = {22'h0, (state == CMFS_FAULT), ~brown, flags};
                cmfs_pkg::REC_OFS:   next_dat = {14'h0, rec};
                cmfs_pkg::SNAPG_OFS: next_dat = {14'h0, snap_g};
                cmfs_pkg::SNAPY_OFS: next_dat = {14'h0, snap_y};
                cmfs_pkg::SNAPR_OFS: next_dat = {14'h0, snap_r};
                default:             next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl      <= cmfs_pkg::CTRL_RESET;
            rfen      <= cmfs_pkg::RFEN_RESET;
            cmd_pulse <= 1'b0;
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= '0;
        end else begin
            ctrl      <= next_ctrl;
            rfen      <= next_rfen;
            cmd_pulse <= next_cmd_pulse;
            wb_ack_o  <= next_ack;
            wb_dat_o  <= next_dat;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    card_fault_a: assert property (@(posedge clk) disable iff (rst)
        !card_present |=> flags[cmfs_pkg::FL_PCA] && state == CMFS_FAULT && fault_active)
        else $error("card absence did not fault");
    fault_hold_a: assert property (@(posedge clk) disable iff (rst)
        state == CMFS_FAULT && !reset_req && !(power_evt && !ctrl[cmfs_pkg::CTRL_WDL_SEL])
        |=> state == CMFS_FAULT)
        else $error("fault left without reset");
    record_hold_a: assert property (@(posedge clk) disable iff (rst)
        state == CMFS_FAULT && !reset_req && !(power_evt && !ctrl[cmfs_pkg::CTRL_WDL_SEL])
        |=> $stable(rec) && $stable(snap_g) && $stable(snap_y) && $stable(snap_r))
        else $error("channel record changed in fault");
    polarity_sel_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl[cmfs_pkg::CTRL_POL_SEL] ? !relay_common_input : relay_common_input) |-> !mon_en && !rf_en)
        else $error("relay common polarity wrong");
    redfail_gate_a: assert property (@(posedge clk) disable iff (rst)
        (|rf_exp) |-> $past(rf_en))
        else $error("red fail timed while gated");
    wdt_autoclr_a: assert property (@(posedge clk) disable iff (rst)
        power_evt && !ctrl[cmfs_pkg::CTRL_WDL_SEL] && !wd_exp |=> !flags[cmfs_pkg::FL_WDT])
        else $error("watchdog fault not cleared by power event");
    wdt_latch_a: assert property (@(posedge clk) disable iff (rst)
        flags[cmfs_pkg::FL_WDT] && ctrl[cmfs_pkg::CTRL_WDL_SEL] && !reset_req |=> flags[cmfs_pkg::FL_WDT])
        else $error("latched watchdog fault lost");
    rf_limit_a: assert property (@(posedge clk) disable iff (rst)
        rf_limit == (ctrl[cmfs_pkg::CTRL_RF_SEL] ? 11'd1350 : 11'd850))
        else $error("red fail time select wrong");
    wb_ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o ##1 (wb_ack_o == $past(wb_cyc_i & wb_stb_i)))
        else $error("ack not a single pulse");
endmodule : cmfs_supervisor
